// File: design/fesc_top.sv
/*
  host controller for a parallel nor flash: pause/continue of sector erase,
  erase result evaluation, status read and the continuity check.
  assumes an avalon-mm master with waitrequest and flash pins on the far side.
*/
`timescale 1ns/1ns
module fesc_top
  import fesc_pkg::*;
#(
  parameter int RESUME_GAP = RESUME_GAP_CY
)(
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [22:0]      flash_a_out,
  output logic             flash_we_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_byte_n_out,
  input  wire logic [15:0] flash_dq_in,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_out
);
  typedef enum {S_IDLE, S_W1, S_W2, S_W3, S_W4, S_W5, S_W6, S_W7, S_DONE} fesc_state_e;
  fesc_state_e state_reg;
  logic [1:0]  rst_sync_reg;
  wire         rst_n = rst_sync_reg[1];
  logic [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_stable_reg;
  logic [3:0]  op_reg;
  logic [22:0] addr_reg;
  logic [15:0] rdata_reg;
  logic        busy_reg, paused_reg, err_reg, cont_ok_reg, erase_bad_reg, ack_reg;
  logic        cont_pre_reg;  // set-up read showed bit 0 clear
  logic [31:0] gap_reg;
  logic        c_req_reg, c_wr_reg;
  logic [22:0] c_addr_reg;
  logic [15:0] c_wdata_reg;
  fesc_cycle_if cyc();
  // reset release and three-stage pin sampling
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1_reg <= '0; dq_s2_reg <= '0; dq_s3_reg <= '0; dq_stable_reg <= '0;
    end
    else if (ce_in)
    begin
      dq_s1_reg <= flash_dq_in; dq_s2_reg <= dq_s1_reg; dq_s3_reg <= dq_s2_reg;
      if (dq_s2_reg == dq_s3_reg)
        dq_stable_reg <= dq_s3_reg;
    end
  end
  fesc_cycle u_cycle (
    .clk_in     (mclk_in),
    .rst_n_in   (rst_n),
    .ce_in      (ce_in),
    .cyc        (cyc.eng),
    .dq_sync_in (dq_stable_reg),
    .we_n_out   (flash_we_n_out),
    .oe_n_out   (flash_oe_n_out),
    .dq_oe_out  (flash_dq_oe_out),
    .a_out      (flash_a_out),
    .dq_o_out   (flash_dq_out)
  );
  assign cyc.req   = c_req_reg;
  assign cyc.wr    = c_wr_reg;
  assign cyc.addr  = c_addr_reg;
  assign cyc.wdata = c_wdata_reg;
  // bus decode
  wire        byte_mode = op_reg[CMD_BYTE_BIT];
  wire [2:0]  op        = op_reg[2:0];
  wire        wr_cmd    = avs_write_in && avs_address_in == REG_CMD;
  wire        start     = wr_cmd && !busy_reg && state_reg == S_IDLE;
  wire [2:0]  new_op    = avs_writedata_in[2:0];
  wire        gap_open  = gap_reg == 32'h0000_0000;
  wire        sr_idle   = !paused_reg;
  // refuse pause too soon after continue, eval while paused
  wire        refuse    = (new_op == OP_PAUSE && (!gap_open || paused_reg))
                        || (new_op == OP_CONTINUE && !paused_reg)
                        || (new_op == OP_EVAL && !sr_idle);
  wire [22:0] unlock    = byte_mode ? B_UNLOCK : {W_UNLOCK, 1'b0};
  wire [22:0] sect_a    = byte_mode ? addr_reg : {addr_reg[21:0], 1'b0};
  wire [15:0] sr_clr    = byte_mode ? {8'h00, CMD_SR_CLEAR} : {8'h00, CMD_SR_CLEAR};
  wire        cdone     = cyc.done;
  // next cycle for each step of each operation
  logic        nx_wr;
  logic [22:0] nx_a;
  logic [15:0] nx_d;
  logic        nx_last;
  always_comb
  begin
    nx_wr = 1'b1; nx_a = unlock; nx_d = {8'h00, CMD_SR_READ}; nx_last = 1'b0;
    unique case (op)
      OP_PAUSE:    begin nx_d = {8'h00, CMD_PAUSE}; nx_last = 1'b1; end
      OP_CONTINUE: begin nx_d = {8'h00, CMD_CONTINUE}; nx_last = 1'b1; end
      OP_EVAL:
        if (state_reg == S_W1)
        begin
          nx_a = sect_a;
          nx_d = {8'h00, CMD_EVAL};
        end
        else if (state_reg == S_W3)
        begin
          nx_wr   = 1'b0;  // poll ready bit until evaluation ends
          nx_last = 1'b1;
        end
      OP_READ:     begin nx_wr = 1'b0; nx_a = sect_a; nx_last = 1'b1; end
      OP_SR_READ:
        if (state_reg == S_W2)
        begin
          nx_wr = 1'b0; nx_last = 1'b1;
        end
      OP_CONT_CHK:
        unique case (state_reg)
          S_W1: nx_d = sr_clr;
          S_W2: nx_d = {8'h00, CMD_SR_READ};
          S_W3: nx_wr = 1'b0;  // set-up read, bit 0 must be clear
          S_W4:
          begin
            nx_a  = byte_mode ? B_PAT1_A : {W_PAT1_A, 1'b0};
            nx_d  = byte_mode ? {8'h00, B_PAT1_D} : W_PAT1_D;
          end
          S_W5:
          begin
            nx_a  = byte_mode ? B_PAT2_A : {W_PAT2_A, 1'b0};
            nx_d  = byte_mode ? {8'h00, B_PAT2_D} : W_PAT2_D;
          end
          S_W6: nx_d = {8'h00, CMD_SR_READ};
          S_W7:
          begin
            nx_wr   = 1'b0;
            nx_last = 1'b1;
          end
          default: nx_last = 1'b1;
        endcase
      default: nx_last = 1'b1;
    endcase
  end
  // sequencer
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE; op_reg <= '0; busy_reg <= 1'b0; paused_reg <= 1'b0;
      err_reg <= 1'b0; c_req_reg <= 1'b0; c_wr_reg <= 1'b0; c_addr_reg <= '0; c_wdata_reg <= '0;
      rdata_reg <= '0; cont_ok_reg <= 1'b0; erase_bad_reg <= 1'b0; gap_reg <= '0;
      cont_pre_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!gap_open)
        gap_reg <= gap_reg - 32'h0000_0001;
      c_req_reg <= 1'b0;
      if (start && refuse)
        err_reg <= 1'b1;
      else if (start)
      begin
        op_reg <= avs_writedata_in[3:0];
        busy_reg <= 1'b1; err_reg <= 1'b0; state_reg <= S_W1;
      end
      else if (state_reg != S_IDLE && state_reg != S_DONE && !c_req_reg && !cyc.done)
      begin
        c_req_reg <= 1'b1; c_wr_reg <= nx_wr; c_addr_reg <= nx_a; c_wdata_reg <= nx_d;
        state_reg <= nx_last ? S_DONE : state_reg;
      end
      if (cdone)
      begin
        rdata_reg <= cyc.rdata;
        if (op == OP_CONT_CHK && state_reg == S_W3)
          cont_pre_reg <= !cyc.rdata[SR_CONT_BIT];
        if (state_reg != S_DONE)
          state_reg <= state_reg.next();
        else if (op == OP_EVAL && !cyc.rdata[SR_READY_BIT])
          state_reg <= S_W2;
        else
        begin
          state_reg <= S_IDLE; busy_reg <= 1'b0;
          if (op == OP_PAUSE) paused_reg <= 1'b1;
          if (op == OP_CONTINUE)
          begin
            paused_reg <= 1'b0; gap_reg <= 32'(RESUME_GAP);
          end
          if (op == OP_SR_READ || op == OP_CONT_CHK || op == OP_EVAL)
            erase_bad_reg <= cyc.rdata[SR_ERASE_BIT];
          if (op == OP_CONT_CHK)
            cont_ok_reg <= cyc.rdata[SR_CONT_BIT] && cont_pre_reg;
        end
      end
    end
  end
  // address register write
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      addr_reg <= '0;
    else if (ce_in && avs_write_in && avs_address_in == REG_ADDR && !busy_reg)
      addr_reg <= avs_writedata_in[22:0];
  end
  // avalon slave: one wait cycle, answer on the second
  wire [31:0] rd_mux = avs_address_in == REG_CMD    ? {28'h0, op_reg} :
                       avs_address_in == REG_ADDR   ? {9'h0, addr_reg} :
                       avs_address_in == REG_STATUS ? {27'h0, erase_bad_reg, cont_ok_reg,
                                                       err_reg, paused_reg, busy_reg} :
                       avs_address_in == REG_RDATA  ? {16'h0, rdata_reg} : 32'h0000_0000;
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0; avs_readdata_out <= '0; avs_waitrequest_out <= 1'b1; flash_byte_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_reg);
      avs_readdata_out <= rd_mux;
      flash_byte_n_out <= !byte_mode;
    end
  end
  // guards on commands as they reach the flash pins, on refused commands and on the bus answer pulse
  sequence we_fall_s;
    $fell(flash_we_n_out);
  endsequence
  sequence ack_once_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  pause_gap_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    we_fall_s ##0 (flash_dq_out[7:0] == CMD_PAUSE) |-> gap_open) else $error("pause too soon after continue");
  eval_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    we_fall_s ##0 (flash_dq_out[7:0] == CMD_EVAL) |-> !paused_reg) else $error("evaluation while paused");
  eval_addr_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    we_fall_s ##0 (op == OP_EVAL && state_reg == S_W1)
    |-> flash_a_out == sect_a && flash_dq_out[7:0] == CMD_EVAL) else $error("evaluation code not at sector");
  cont_code_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    we_fall_s ##0 (op == OP_CONTINUE) |-> flash_dq_out[7:0] == CMD_CONTINUE) else $error("continue code wrong");
  refuse_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    start && refuse && ce_in |=> err_reg && !busy_reg) else $error("refused command not flagged");
  ack_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $fell(avs_waitrequest_out) |-> ack_once_s) else $error("waitrequest low for more than one cycle");
endmodule

// File: design/fesc_pkg.sv
/*
  package for the flash erase/suspend/status host controller: command codes,
  pattern addresses, register offsets and bus cycle timing.
  assumes a parallel nor flash on the far side of the pins, x16 or x8 mode.
*/
package fesc_pkg;
  localparam int ADDR_W = 23;  // top_address_line..a-1
  localparam int DATA_W = 16;
  // command codes
  localparam logic [7:0] CMD_PAUSE    = 8'h0_B0;
  localparam logic [7:0] CMD_CONTINUE = 8'h0_30;
  localparam logic [7:0] CMD_EVAL     = 8'h0_35;
  localparam logic [7:0] CMD_SR_READ  = 8'h0_70;
  localparam logic [7:0] CMD_SR_CLEAR = 8'h0_71;
  // word mode addresses (bit 0 of the 23 bit bus is a-1, unused in word mode)
  localparam logic [21:0] W_UNLOCK  = 22'h00_0555;
  localparam logic [21:0] W_PAT1_A  = 22'h2A_AA55;
  localparam logic [21:0] W_PAT2_A  = 22'h15_55AA;
  localparam logic [15:0] W_PAT1_D  = 16'hFF00;
  localparam logic [15:0] W_PAT2_D  = 16'h00FF;
  // byte mode addresses
  localparam logic [22:0] B_UNLOCK  = 23'h00_0AAA;
  localparam logic [22:0] B_PAT1_A  = 23'h55_54AB;
  localparam logic [22:0] B_PAT2_A  = 23'h2A_AB54;
  localparam logic [7:0]  B_PAT1_D  = 8'hFF;
  localparam logic [7:0]  B_PAT2_D  = 8'h00;
  // status bits
  localparam int SR_READY_BIT  = 7;
  localparam int SR_ERASE_BIT  = 5;
  localparam int SR_CONT_BIT   = 0;
  // register offsets (byte addresses)
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA  = 4'hC;
  // command register op field
  localparam logic [2:0] OP_PAUSE    = 3'h1;
  localparam logic [2:0] OP_CONTINUE = 3'h2;
  localparam logic [2:0] OP_EVAL     = 3'h3;
  localparam logic [2:0] OP_SR_READ  = 3'h4;
  localparam logic [2:0] OP_CONT_CHK = 3'h5;
  localparam logic [2:0] OP_READ     = 3'h6;
  localparam int CMD_BYTE_BIT = 3;
  // timing
  localparam int CLK_NS        = 10;
  localparam int BUS_STROBE_NS = 70;
  localparam int BUS_STROBE_CY = (BUS_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESUME_GAP_US = 100;
  localparam int RESUME_GAP_CY = RESUME_GAP_US * 1000 / CLK_NS;
endpackage

// File: design/fesc_cycle_if.sv
/*
  interface between sequencer and bus-cycle engine.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface fesc_cycle_if;
  logic        req;
  logic        wr;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// File: design/fesc_cycle.sv
/*
  bus-cycle engine: one flash write or read with a fixed strobe width.
  assumes flash data input is already synchronised by the caller.
*/
`timescale 1ns/1ns
module fesc_cycle
  import fesc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  fesc_cycle_if.eng        cyc,
  input  wire logic [15:0] dq_sync_in,
  output logic             we_n_out,
  output logic             oe_n_out,
  output logic             dq_oe_out,
  output logic [22:0]      a_out,
  output logic [15:0]      dq_o_out
);
  localparam logic [3:0] STROBE = 4'(BUS_STROBE_CY + 2);
  logic [3:0]  cnt_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [15:0] rdata_reg;
  wire         last = busy_reg && cnt_reg == 4'h1;
  assign cyc.done  = done_reg;
  assign cyc.rdata = rdata_reg;
  // strobe sequencing; data sampled at the end of the strobe
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= '0; busy_reg <= 1'b0; done_reg <= 1'b0; rdata_reg <= '0;
      we_n_out <= 1'b1; oe_n_out <= 1'b1; dq_oe_out <= 1'b0; a_out <= '0; dq_o_out <= '0;
    end
    else if (ce_in)
    begin
      done_reg <= 1'b0;
      if (!busy_reg && cyc.req && !done_reg)
      begin
        busy_reg <= 1'b1; cnt_reg <= STROBE; a_out <= cyc.addr; dq_o_out <= cyc.wdata;
        dq_oe_out <= cyc.wr; we_n_out <= !cyc.wr; oe_n_out <= cyc.wr;
      end
      else if (last)
      begin
        busy_reg <= 1'b0; done_reg <= 1'b1; rdata_reg <= dq_sync_in;
        we_n_out <= 1'b1; oe_n_out <= 1'b1; dq_oe_out <= 1'b0;
      end
      else if (busy_reg)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
  strobe_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(we_n_out) && ce_in |-> !we_n_out [*3]) else $error("write strobe too short");
endmodule

// File: verification/fesc_flash_model.sv
/*
  behavioural parallel nor flash for the host controller bench: sector erase with
  pause and continue, erase result evaluation, status register and continuity check.
  assumes the controller's pins and the bench clock; the erase is started by the bench.
*/
`timescale 1ns/1ns
module fesc_flash_model
  import fesc_pkg::*;
#(
  parameter int PAUSE_LAT = 30,
  parameter int QUEUE_CY  = 40,
  parameter int EVAL_CY   = 50,
  parameter int GAP       = 200
)(
  input  wire logic        clk_in,
  input  wire logic        erase_go_in,
  input  wire logic        eval_fail_in,
  input  wire logic [22:0] a_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        byte_n_in,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             gap_bad_out,
  output logic             eval_bad_out,
  output logic [22:0]      eval_a_out
);
  typedef enum logic [2:0] {FM_IDLE, FM_QUEUE, FM_ERASE, FM_STOP, FM_PAUSED, FM_EVAL} fesc_fm_e;
  fesc_fm_e    st = FM_IDLE;
  int          cnt = 0;
  int          gap = 0;
  logic        we_q = 1'b1, oe_q = 1'b1, sr_rd = 1'b0, tog = 1'b0, p1 = 1'b0, cont = 1'b0, fail = 1'b0;
  logic [22:0] wa = '0;
  logic [15:0] wd = '0, last = '0, rd_val;
  logic [7:0]  sr;
  logic        sel, p2;
  // status byte: ready, paused, erase result, continuity
  assign sr  = {st == FM_IDLE || st == FM_PAUSED, st == FM_PAUSED, fail, 4'h0, cont};
  assign sel = a_in[22:17] == 6'h3F && st inside {FM_ERASE, FM_STOP, FM_PAUSED};
  assign p2  = byte_n_in ? (wa[22:1] == W_PAT2_A && wd == W_PAT2_D) : (wa == B_PAT2_A && wd[7:0] == B_PAT2_D);
  // read data: status, toggling bits in the erase sector, the inverted last read during evaluation, or array pattern
  assign rd_val = sr_rd ? {8'h00, sr}
                : sel ? {8'h00, 1'b0, tog & (st != FM_PAUSED), 3'h0, tog, 2'h0}
                : st == FM_EVAL ? ~last : a_in[16:1] ^ 16'hA5C3;
  assign dq_out = !oe_n_in ? rd_val : ~last;  // released bus shows no stale value
  // command decode once a write strobe has ended
  always @(posedge clk_in)
  begin
    we_q <= we_n_in;
    oe_q <= oe_n_in;
    cnt  <= cnt + 1;
    gap  <= gap + 1;
    if (!we_n_in)
    begin
      wa <= a_in;
      wd <= dq_in;
    end
    if (!oe_n_in)
      last <= dq_out;
    if (erase_go_in)
    begin
      st  <= FM_QUEUE;
      cnt <= 0;
    end
    if (st == FM_QUEUE && cnt == QUEUE_CY) st <= FM_ERASE;
    if (st == FM_STOP && cnt == PAUSE_LAT) st <= FM_PAUSED;
    if (st == FM_EVAL && cnt == EVAL_CY) st <= FM_IDLE;
    if (oe_n_in && !oe_q)
    begin
      sr_rd <= 1'b0;
      if (sel) tog <= !tog;
    end
    if (we_n_in && !we_q)
    begin
      p1 <= byte_n_in ? (wa[22:1] == W_PAT1_A && wd == W_PAT1_D) : (wa == B_PAT1_A && wd[7:0] == B_PAT1_D);
      if (p1 && p2) cont <= 1'b1;
      case (wd[7:0])
        CMD_SR_CLEAR: cont <= 1'b0;
        CMD_SR_READ:  sr_rd <= 1'b1;
        CMD_PAUSE:
          if (st == FM_QUEUE) st <= FM_PAUSED;
          else if (st == FM_ERASE)
          begin
            st          <= FM_STOP;
            cnt         <= 0;
            gap_bad_out <= gap_bad_out | (gap < GAP);
          end
        CMD_CONTINUE:
          if (st == FM_PAUSED)
          begin
            st  <= FM_ERASE;
            gap <= 0;
          end
        CMD_EVAL:
        begin
          eval_bad_out <= eval_bad_out | (st != FM_IDLE);
          if (st == FM_IDLE)
          begin
            st         <= FM_EVAL;
            cnt        <= 0;
            fail       <= eval_fail_in;
            eval_a_out <= wa;
          end
        end
        default: ;  // other codes leave the erase state alone
      endcase
    end
  end
  initial
  begin
    gap_bad_out  = 1'b0;
    eval_bad_out = 1'b0;
    eval_a_out   = '0;
  end
endmodule

// File: verification/flash_erase_suspend_status_check_bench.sv
/*
  self-checking bench for the flash host controller: drives the avalon-mm side,
  a flash model stands on the pins.
  assumes the design package and a 100 MHz clock.
*/
`timescale 1ns/1ns
module flash_erase_suspend_status_check_bench
  import fesc_pkg::*;
;
  localparam int GAP = 200;
  logic        mclk_in = 1'b0, arst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0]  avs_address_in = '0;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
  logic        avs_waitrequest_out, we_n, oe_n, byte_n, dq_oe, gap_bad, eval_bad;
  logic        erase_go = 1'b0, eval_fail = 1'b0;
  logic [22:0] fa, eval_a;
  logic [15:0] dq_o, dq_i;
  int          miscompares = 0, n_compared = 0;
  // clock, 10 ns period
  always #5 mclk_in = !mclk_in;
  fesc_top #(.RESUME_GAP(GAP)) i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .flash_a_out(fa), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_byte_n_out(byte_n), .flash_dq_in(dq_i), .flash_dq_out(dq_o),
    .flash_dq_oe_out(dq_oe));
  fesc_flash_model #(.GAP(GAP)) i_flash (.clk_in(mclk_in), .erase_go_in(erase_go), .eval_fail_in(eval_fail),
    .a_in(fa), .we_n_in(we_n), .oe_n_in(oe_n), .byte_n_in(byte_n), .dq_in(dq_oe ? dq_o : ~dq_o),
    .dq_out(dq_i), .gap_bad_out(gap_bad), .eval_bad_out(eval_bad), .eval_a_out(eval_a));
  task automatic complete_run;
    $display("miscompares %0d, compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      avs_address_in   <= a;
      avs_write_in     <= wr;
      avs_read_in      <= !wr;
      avs_writedata_in <= d;
      n = 0;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 500)
      begin
        @(posedge mclk_in);
        n++;
      end
      cmp(32'(n < 500), 32'h0000_0001, "bus answer");
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  // issue a command and poll until the controller is idle
  task automatic op(input logic [31:0] c);
    int n;
    begin
      bus(1'b1, REG_CMD, c);
      n = 0;
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      while (q[0] !== 1'b0 && n < 3000)
      begin
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        n++;
      end
      cmp(32'(n < 3000), 32'h0000_0001, "idle wait");
    end
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp(q & mask, exp, "register read");
  endtask
  task automatic reset_values;
    chk(REG_STATUS, 32'h0000_001F, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);  // unmapped offset must still answer
  endtask
  task automatic continuity_both;
    op(32'(OP_CONT_CHK));
    chk(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    op(32'(OP_CONT_CHK) | 32'h0000_0008);
    chk(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    op(32'(OP_SR_READ));
    chk(REG_RDATA, 32'h0000_00FF, 32'h0000_0081);
  endtask
  task automatic evaluate(input logic f);
    eval_fail <= f;
    bus(1'b1, REG_ADDR, 32'h0015_0000);
    op(32'(OP_EVAL));
    chk(REG_STATUS, 32'h0000_0010, f ? 32'h0000_0010 : 32'h0000_0000);
    cmp(32'(eval_a[22:1]), 32'h0015_0000, "eval address");
    op(32'(OP_SR_READ));
    chk(REG_RDATA, 32'h0000_00A0, f ? 32'h0000_00A0 : 32'h0000_0080);
  endtask
  task automatic pause_resume;
    erase_go <= 1'b1;
    @(posedge mclk_in);
    erase_go <= 1'b0;
    op(32'(OP_PAUSE));
    chk(REG_STATUS, 32'h0000_0002, 32'h0000_0002);
    bus(1'b1, REG_ADDR, 32'h0000_1234);
    op(32'(OP_READ));
    chk(REG_RDATA, 32'h0000_FFFF, 32'h0000_1234 ^ 32'h0000_A5C3);
    bus(1'b1, REG_ADDR, 32'h003F_0000);
    op(32'(OP_READ));
    chk(REG_RDATA, 32'h0000_FFFF, 32'h0000_0000);
    op(32'(OP_READ));
    chk(REG_RDATA, 32'h0000_FFFF, 32'h0000_0004);
    op(32'(OP_EVAL));
    chk(REG_STATUS, 32'h0000_0006, 32'h0000_0006);
    op(32'(OP_CONTINUE));
    chk(REG_STATUS, 32'h0000_0002, 32'h0000_0000);
    op(32'(OP_CONTINUE));
    chk(REG_STATUS, 32'h0000_0006, 32'h0000_0004);
    op(32'(OP_PAUSE));
    chk(REG_STATUS, 32'h0000_0006, 32'h0000_0004);
    repeat (GAP) @(posedge mclk_in);
    op(32'(OP_PAUSE));
    chk(REG_STATUS, 32'h0000_0002, 32'h0000_0002);
    cmp(32'(gap_bad), 32'h0000_0000, "pause spacing");
    cmp(32'(eval_bad), 32'h0000_0000, "eval while busy");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    reset_values();
    continuity_both();
    evaluate(1'b0);
    evaluate(1'b1);
    pause_resume();
    complete_run();
  end
  // watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    miscompares++;
    complete_run();
  end
endmodule
